/* File: design/ebs_port_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "ebs_regs.vh"
module ebs_port_ctrl (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire bus_master,
    input wire acc_req,
    input wire acc_write,
    input wire [3:0] acc_attr_sel,
    input wire [3:0] acc_attr_addr,
    output wire acc_done,
    output wire acc_busy,
    input wire transfer_ack_n,
    output wire read_strobe_n_o,
    output wire read_strobe_oe,
    output wire write_strobe_n_o,
    output wire write_strobe_oe,
    output wire [3:0] addr_attribute_select_o,
    output wire [3:0] addr_attribute_select_oe
);

    // Sequencer states; a stretched access spends its wait states in ST_WAIT.
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_ACK = 2'h2;
    localparam ST_END = 2'h3;

    // Decode a byte address into a register select; unmapped returns 2'h3.
    function [1:0] reg_sel;
        input [31:0] addr;
        begin
            case (addr[3:0])
                `EBS_CTRL_OFF: reg_sel = 2'h0;
                `EBS_ATTR_OFF: reg_sel = 2'h1;
                `EBS_STAT_OFF: reg_sel = 2'h2;
                default: reg_sel = 2'h3;
            endcase
            if (addr[31:4] != 28'h0) begin
                reg_sel = 2'h3;
            end
        end
    endfunction

    // Software-visible configuration.
    reg [31:0] bus_control_reg_q;
    reg [31:0] attr_cfg_q;
    // Register bus channel state.
    reg aw_held_q;
    reg w_held_q;
    reg bvalid_q;
    reg rvalid_q;
    reg [31:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [31:0] rdata_q;
    reg [3:0] wstrb_q;
    reg [1:0] bresp_q;
    reg [1:0] rresp_q;
    // External cycle state, captured at the start of each access.
    reg [1:0] state_q;
    reg [4:0] wait_cnt_q;
    reg cyc_write_q;
    reg cyc_row_q;
    reg done_q;
    reg [3:0] cyc_sel_q;
    reg [3:0] cyc_addr_q;
    // Acknowledge synchroniser and pin registers.
    reg ack_meta_q;
    reg ack_sync_q;
    reg rd_n_q;
    reg wr_n_q;
    reg [3:0] attr_q;
    reg ack_seen_q;
    // Decoded control fields and register bus selects.
    wire [4:0] min_wait = bus_control_reg_q[`EBS_CTRL_WAIT_MSB:`EBS_CTRL_WAIT_LSB];
    wire ack_async_sel = bus_control_reg_q[`EBS_CTRL_SYNC_BIT];
    wire standby = bus_control_reg_q[`EBS_CTRL_STDBY_BIT];
    wire owner = bus_master & ~standby;
    wire ack_level;
    wire [1:0] wsel = reg_sel(awaddr_q);
    wire [1:0] rsel = reg_sel(s_axi_araddr);
    wire do_write = aw_held_q & w_held_q & ~bvalid_q;
    integer b;

    // AXI4-Lite handshakes: each channel accepts once, response after both.
    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready = ~w_held_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Write path and register storage with byte enables.
    // The response is raised only once both address and data are held.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bresp_q <= `EBS_RESP_OKAY;
            bus_control_reg_q <= `EBS_CTRL_RST;
            attr_cfg_q <= `EBS_ATTR_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (wsel == 2'h0 || wsel == 2'h1) ? `EBS_RESP_OKAY : `EBS_RESP_SLVERR;
                for (b = 0; b < 4; b = b + 1) begin
                    if (wstrb_q[b] && wsel == 2'h0) begin
                        bus_control_reg_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
                    end
                    if (wstrb_q[b] && wsel == 2'h1) begin
                        attr_cfg_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
                    end
                end
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read path; status shows the cycle state, wait count and strobes.
    // Unmapped addresses answer with an error and all-zero data.
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `EBS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= (rsel == 2'h3) ? `EBS_RESP_SLVERR : `EBS_RESP_OKAY;
            case (rsel)
                2'h0: rdata_q <= bus_control_reg_q & 32'h0000_031f;
                2'h1: rdata_q <= attr_cfg_q & 32'h0000_0fff;
                2'h2: rdata_q <= {16'h0, ack_seen_q, owner, rd_n_q, wr_n_q, attr_q, 1'b0, wait_cnt_q, state_q};
                default: rdata_q <= 32'h0;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Acknowledge: two-stage synchroniser in asynchronous mode, direct in synchronous mode.
    // Only the second stage reads the first, which keeps metastability out of the sequencer.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ack_meta_q <= 1'b0;
            ack_sync_q <= 1'b0;
        end else begin
            ack_meta_q <= ~transfer_ack_n;
            ack_sync_q <= ack_meta_q;
        end
    end
    assign ack_level = ack_async_sel ? ack_sync_q : ~transfer_ack_n;

    // External cycle sequencer.
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            wait_cnt_q <= 5'h0;
            cyc_write_q <= 1'b0;
            cyc_row_q <= 1'b0;
            cyc_sel_q <= 4'h0;
            cyc_addr_q <= 4'h0;
            done_q <= 1'b0;
            ack_seen_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (acc_req && owner) begin
                        state_q <= ST_WAIT;
                        wait_cnt_q <= 5'h0;
                        cyc_write_q <= acc_write;
                        cyc_sel_q <= acc_attr_sel;
                        cyc_addr_q <= acc_attr_addr;
                        // Row mode is latched so a later mode change cannot alter this cycle's timing.
                        cyc_row_q <= |(acc_attr_sel & {attr_cfg_q[7], attr_cfg_q[5], attr_cfg_q[3], attr_cfg_q[1]});
                        ack_seen_q <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    if (!owner) begin
                        state_q <= ST_IDLE;
                    end else if (wait_cnt_q < min_wait) begin
                        // Programmed minimum first; acknowledge cannot shorten it.
                        wait_cnt_q <= wait_cnt_q + 5'h1;
                    end else if (min_wait == 5'h0 || cyc_row_q) begin
                        // Zero-wait and row accesses run on programmed timing alone.
                        state_q <= ST_END;
                    end else if (ack_level) begin
                        state_q <= ST_ACK;
                        ack_seen_q <= 1'b1;
                    end else if (wait_cnt_q != 5'h1f) begin
                        // The count saturates, but the cycle stays stretched while acknowledge is off.
                        wait_cnt_q <= wait_cnt_q + 5'h1;
                    end
                end
                ST_ACK: begin
                    if (!owner) begin
                        state_q <= ST_IDLE;
                    end else begin
                        state_q <= ST_END;
                    end
                end
                ST_END: begin
                    state_q <= ST_IDLE;
                    done_q <= 1'b1;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // Acknowledge is looked at only in ST_WAIT once the minimum has run out, so the
    // longer of the programmed and the acknowledge-imposed waits wins, except in zero-wait and row accesses.

    // Pin drivers: strobes and attribute lines registered, active only during the cycle.
    // Registering the pins keeps them free of decode glitches.
    wire cyc_on = (state_q == ST_WAIT) || (state_q == ST_ACK);
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_attr
            wire [1:0] mode = attr_cfg_q[2*g +: 2];
            wire pol = attr_cfg_q[`EBS_ATTR_POL_LSB + g];
            wire act = (mode == `EBS_MODE_ADDR) ? cyc_addr_q[g] : cyc_sel_q[g];
            always @(posedge aclk) begin
                if (!aresetn) begin
                    // Reset polarity is active low, so the idle level is high.
                    attr_q[g] <= 1'b1;
                end else begin
                    attr_q[g] <= (cyc_on && owner && act) ? pol : ~pol;
                end
            end
            assign addr_attribute_select_oe[g] = owner;
        end
    endgenerate

    // Read and write strobes, high outside a cycle and from the first edge at which the bus is not owned.
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else begin
            rd_n_q <= ~(cyc_on && owner && !cyc_write_q);
            wr_n_q <= ~(cyc_on && owner && cyc_write_q);
        end
    end

    // Output enables follow ownership directly, so release is immediate.
    assign addr_attribute_select_o = attr_q;
    assign read_strobe_n_o = rd_n_q;
    assign write_strobe_n_o = wr_n_q;
    assign read_strobe_oe = owner;
    assign write_strobe_oe = owner;
    assign acc_done = done_q;
    assign acc_busy = (state_q != ST_IDLE);

endmodule // ebs_port_ctrl
`default_nettype wire

/* File: design/ebs_regs.vh */
`ifndef EBS_REGS_VH
`define EBS_REGS_VH
// Register byte offsets on the AXI4-Lite slave.
`define EBS_CTRL_OFF 4'h0
`define EBS_ATTR_OFF 4'h4
`define EBS_STAT_OFF 4'h8
// Control register fields.
`define EBS_CTRL_WAIT_LSB 0
`define EBS_CTRL_WAIT_MSB 4
`define EBS_CTRL_SYNC_BIT 8
`define EBS_CTRL_STDBY_BIT 9
`define EBS_CTRL_RST 32'h0000_0001
// Attribute register: per line mode (2 bits) at 0..7, polarity at 8..11.
`define EBS_ATTR_POL_LSB 8
`define EBS_ATTR_RST 32'h0000_0000
// Line modes.
`define EBS_MODE_CS 2'h0
`define EBS_MODE_ADDR 2'h1
`define EBS_MODE_ROW 2'h2
// AXI responses.
`define EBS_RESP_OKAY 2'h0
`define EBS_RESP_SLVERR 2'h2
`endif

/* File: testbench/ebs_port_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ebs_port_ctrl_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic bus_master,
    input wire logic acc_done,
    input wire logic acc_busy,
    input wire logic read_strobe_n_o,
    input wire logic read_strobe_oe,
    input wire logic write_strobe_n_o,
    input wire logic write_strobe_oe,
    input wire logic [3:0] addr_attribute_select_oe
);
    // All checks run on the core clock and rest while reset is held.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rd_oe_owner_a: assert property (!bus_master |-> !read_strobe_oe) else $error("read strobe driven");
    wr_oe_owner_a: assert property (!bus_master |-> !write_strobe_oe) else $error("write strobe driven");
    attr_oe_owner_a: assert property (!bus_master |-> addr_attribute_select_oe == 4'h0)
        else $error("attribute lines driven");
    oe_together_a: assert property (read_strobe_oe == write_strobe_oe && addr_attribute_select_oe == {4{read_strobe_oe}})
        else $error("port enables disagree");
    strobe_excl_a: assert property (read_strobe_n_o || write_strobe_n_o) else $error("both strobes low");
    done_pulse_a: assert property (acc_done |=> !acc_done) else $error("done longer than one cycle");
    done_release_a: assert property (acc_done |-> read_strobe_n_o && write_strobe_n_o)
        else $error("strobe held at cycle end");
    abort_idle_a: assert property (!bus_master |=> !acc_busy) else $error("cycle runs without ownership");
    rd_busy_a: assert property (!read_strobe_n_o && bus_master && $past(bus_master) |-> acc_busy)
        else $error("read strobe outside a cycle");
    wr_busy_a: assert property (!write_strobe_n_o && bus_master && $past(bus_master) |-> acc_busy)
        else $error("write strobe outside a cycle");
endmodule // ebs_port_ctrl_sva
`default_nettype wire

/* File: testbench/ebs_ack_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ebs_ack_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic read_strobe_n_o,
    input wire logic write_strobe_n_o,
    input wire logic [7:0] ack_delay,
    output logic transfer_ack_n
);
    logic [7:0] cnt_q;
    wire strobe = !read_strobe_n_o || !write_strobe_n_o;
    // Counts the cycles that the current bus cycle has shown a strobe.
    always @(posedge aclk) begin
        cnt_q <= (!aresetn || !strobe) ? 8'h00 : cnt_q + 8'h01;
    end
    // Off at cycle start unless the delay is zero, on after the delay, off again between cycles.
    assign transfer_ack_n = !(strobe && cnt_q >= ack_delay);
endmodule // ebs_ack_model
`default_nettype wire

/* File: testbench/ebs_port_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ebs_regs.vh"
module ebs_port_ctrl_bench;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, rdata_c;
    logic [3:0] s_axi_wstrb = 4'hf, acc_attr_sel = 4'h0, acc_attr_addr = 4'h0, pins;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic bus_master = 1'h1, acc_req = 1'h0, acc_write = 1'h0, ta, tw, tb;
    logic [1:0] resp_c, strb_c;
    logic [7:0] ack_delay = 8'h00;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, acc_done, acc_busy;
    wire transfer_ack_n, read_strobe_n_o, read_strobe_oe, write_strobe_n_o, write_strobe_oe;
    wire [3:0] addr_attribute_select_o, addr_attribute_select_oe;
    int bad_count = 0, n_compared = 0, lat, la;
    ebs_port_ctrl dut (.*);
    ebs_ack_model partner (.aclk, .aresetn, .read_strobe_n_o, .write_strobe_n_o, .ack_delay, .transfer_ack_n);
    // Free running core clock of 4 ns.
    always #2 aclk = ~aclk;
    task chk(input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("Checks %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task wr(input logic [31:0] a, d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            resp_c = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end while (!tb);
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask
    task rd(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge aclk);
            ta = s_axi_arready;
            tb = s_axi_rvalid;
            rdata_c = s_axi_rdata;
            resp_c = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'h0;
        end while (!tb);
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask
    task cfg(input logic s, a, input logic [4:0] w);
        wr(`EBS_CTRL_OFF, {22'h0, s, a, 3'h0, w});
    endtask
    // Runs one external access, timing it and noting strobes and lines.
    task acc(input logic w, input logic [3:0] s);
        acc_write <= w;
        acc_attr_sel <= s;
        acc_req <= 1'h1;
        lat = 0;
        @(posedge aclk);
        acc_req <= 1'h0;
        do begin
            @(negedge aclk);
            lat++;
            if ((read_strobe_n_o & write_strobe_n_o) !== 1'h1) begin
                strb_c = {write_strobe_n_o, read_strobe_n_o};
                pins = addr_attribute_select_o;
            end
        end while (acc_done !== 1'h1);
        @(posedge aclk);
    endtask
    task t_stretch_and_min;
        cfg(0, 0, 1);
        ack_delay <= 8'h04;
        acc(0, 4'h1);
        la = lat;
        chk(strb_c, 2'h2);
        ack_delay <= 8'h08;
        acc(0, 4'h1);
        chk(lat - la, 4);
        ack_delay <= 8'h01;
        cfg(0, 0, 8);
        acc(1, 4'h1);
        la = lat;
        chk(strb_c, 2'h1);
        ack_delay <= 8'h04;
        acc(1, 4'h1);
        chk(lat, la);
        ack_delay <= 8'h01;
        cfg(0, 0, 4);
        acc(1, 4'h1);
        chk(la - lat, 4);
        $display("stretch and minimum wait test done");
    endtask
    task t_zero_async;
        cfg(0, 0, 0);
        acc(0, 4'h1);
        la = lat;
        ack_delay <= 8'h14;
        acc(0, 4'h1);
        chk(lat, la);
        ack_delay <= 8'h04;
        cfg(0, 0, 1);
        acc(0, 4'h1);
        la = lat;
        cfg(0, 1, 1);
        acc(0, 4'h1);
        chk(lat - la, 2);
        $display("zero wait and async test done");
    endtask
    task t_attr;
        wr(`EBS_ATTR_OFF, 32'h324);
        cfg(0, 0, 3);
        acc_attr_addr <= 4'h2;
        ack_delay <= 8'h00;
        acc(0, 4'h7);
        la = lat;
        chk(pins, 4'hb);
        @(negedge aclk);
        chk(addr_attribute_select_o, 4'hc);
        @(posedge aclk);
        ack_delay <= 8'h14;
        acc(0, 4'h7);
        chk(lat, la);
        wr(`EBS_ATTR_OFF, `EBS_ATTR_RST);
        $display("attribute line test done");
    endtask
    task t_owner;
        bus_master <= 1'h0;
        acc_req <= 1'h1;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        chk({read_strobe_oe, write_strobe_oe, addr_attribute_select_oe, acc_busy}, 0);
        @(posedge aclk);
        acc_req <= 1'h0;
        bus_master <= 1'h1;
        cfg(1, 0, 1);
        @(negedge aclk);
        chk({read_strobe_oe, write_strobe_oe, addr_attribute_select_oe}, 0);
        @(posedge aclk);
        cfg(0, 0, 1);
        $display("ownership test done");
    endtask
    // Reset, register defaults, then the access scenarios.
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(`EBS_CTRL_OFF);
        chk(rdata_c, `EBS_CTRL_RST);
        rd(32'h10);
        chk(resp_c, `EBS_RESP_SLVERR);
        wr(`EBS_STAT_OFF, 32'h0);
        chk(resp_c, `EBS_RESP_SLVERR);
        cfg(0, 0, 1);
        chk(resp_c, `EBS_RESP_OKAY);
        t_stretch_and_min;
        t_zero_async;
        t_attr;
        t_owner;
        give_verdict;
    end
    // Cuts the run short if an access or bus transfer hangs.
    initial begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        give_verdict;
    end
endmodule // ebs_port_ctrl_bench
bind ebs_port_ctrl ebs_port_ctrl_sva chk_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus_master(bus_master),
    .acc_done(acc_done),
    .acc_busy(acc_busy),
    .read_strobe_n_o(read_strobe_n_o),
    .read_strobe_oe(read_strobe_oe),
    .write_strobe_n_o(write_strobe_n_o),
    .write_strobe_oe(write_strobe_oe),
    .addr_attribute_select_oe(addr_attribute_select_oe)
);
`default_nettype wire
